//--- rtl/assl_pkg.sv
// constants, register map and types of the audio sync source selector
package assl_pkg;

	// ==========================================================
	// clock and sample rates
	localparam int CLK_HZ = 20000000;
	localparam int FS_48K_HZ = 48000;
	localparam int FS_44K1_HZ = 44100;
	localparam int FS_96K_HZ = 96000;
	localparam int FS_88K2_HZ = 88200;
	localparam int DIV_W = 9;
	localparam logic [DIV_W-1:0] HALF_48 = DIV_W'(CLK_HZ / (2 * FS_48K_HZ));
	localparam logic [DIV_W-1:0] HALF_44 = DIV_W'(CLK_HZ / (2 * FS_44K1_HZ));
	localparam logic [DIV_W-1:0] HALF_96 = DIV_W'(CLK_HZ / (2 * FS_96K_HZ));
	localparam logic [DIV_W-1:0] HALF_88 = DIV_W'(CLK_HZ / (2 * FS_88K2_HZ));
	localparam logic [1:0] RATE_48 = 2'h0;
	localparam logic [1:0] RATE_44 = 2'h1;
	localparam logic [1:0] RATE_96 = 2'h2;
	localparam logic [1:0] RATE_88 = 2'h3;
	localparam logic [3:0] HOLD_CYC = 4'h4;

	// ==========================================================
	// source codes
	localparam int N_SRC = 9;
	localparam int SRC_W = 4;
	localparam logic [3:0] SRC_INT = 4'h0;
	localparam logic [3:0] SRC_WC1 = 4'h1;
	localparam logic [3:0] SRC_WC2 = 4'h2;
	localparam logic [3:0] SRC_MADI_A = 4'h3;
	localparam logic [3:0] SRC_MADI_B = 4'h4;
	localparam logic [3:0] SRC_AES_TP = 4'h5;
	localparam logic [3:0] SRC_AES1 = 4'h6;
	localparam logic [3:0] SRC_AES2 = 4'h7;
	localparam logic [3:0] SRC_VIDEO = 4'h8;

	// ==========================================================
	// register map
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_COAX = 12'h004;
	localparam logic [11:0] OFS_STAT = 12'h008;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] COAX_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK = 32'h0000_7FFF;
	localparam logic [31:0] COAX_MASK = 32'h0000_000F;
	localparam int CTL_S1_LSB = 0;
	localparam int CTL_S2_LSB = 4;
	localparam int CTL_S1_EN = 8;
	localparam int CTL_S2_EN = 9;
	localparam int CTL_RATE_LSB = 10;
	localparam int CTL_JIT = 12;
	localparam int CTL_C2OUT = 13;
	localparam int CTL_C2FALL = 14;
	localparam int CX_C1_FALL = 0;
	localparam int CX_C1_TERM = 1;
	localparam int CX_C2_FALL = 2;
	localparam int CX_C2_TERM = 3;
	localparam int STS_REF_LSB = 0;
	localparam int STS_SRC_LSB = 2;
	localparam int STS_PLL = 6;
	localparam int STS_C2OE = 7;
	localparam int STS_VLD_LSB = 8;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		REF_INT = 2'b00,
		REF_S1 = 2'b01,
		REF_S2 = 2'b10
	} assl_ref_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_PARK = 2'b01,
		ST_HOLD = 2'b10
	} assl_state_t;

endpackage

//--- rtl/assl_edge_tap.sv
// synchroniser and edge picker for one reference input
`timescale 1ns/1ps
module assl_edge_tap import assl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin and edge choice
	input wire logic pin,
	input wire logic fall_sel,
	// edge pulse
	output logic edge_pulse
);
	logic m_q, s_q, p_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			m_q <= 1'b0;
			s_q <= 1'b0;
			p_q <= 1'b0;
		end else begin
			m_q <= pin;
			s_q <= m_q;
			p_q <= s_q;
		end
	end

	assign edge_pulse = fall_sel ? (p_q & ~s_q) : (s_q & ~p_q);

	// ==========================================================
	// checks
	edge_fall_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		($fell(s_q) && fall_sel) |-> edge_pulse)
		else $error("falling edge missed");
	edge_rise_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		($fell(s_q) && !fall_sel) |-> !edge_pulse)
		else $error("falling edge taken in rising mode");
endmodule

//--- rtl/assl_sync_selector.sv
// sync source selector with failover and glitch-free clock switch
`timescale 1ns/1ps
module assl_sync_selector import assl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reference receivers
	input wire logic [N_SRC-1:1] ref_pin,
	input wire logic [N_SRC-1:1] src_valid,
	// clock outputs
	output logic sys_clk,
	output logic [SRC_W-1:0] ref_src,
	output logic [1:0] ref_active,
	output logic [1:0] rate_sel,
	output logic wide_range_pll,
	// coaxial controls
	output logic coax1_term,
	output logic coax2_term,
	output logic coax2_out,
	output logic coax2_oe
);

	// ==========================================================
	// functions
	function automatic logic is_coax2(input logic [SRC_W-1:0] s);
		is_coax2 = (s == SRC_WC2) || (s == SRC_AES2);
	endfunction

	function automatic logic is_coax1(input logic [SRC_W-1:0] s);
		is_coax1 = (s == SRC_WC1) || (s == SRC_AES1) || (s == SRC_VIDEO);
	endfunction

	function automatic logic src_ok(input logic [SRC_W-1:0] s,
		input logic [N_SRC-1:0] v);
		src_ok = (s < SRC_W'(N_SRC)) && v[s];
	endfunction

	function automatic logic [DIV_W-1:0] half_cnt(input logic [1:0] r);
		case (r)
			RATE_48: half_cnt = HALF_48;
			RATE_44: half_cnt = HALF_44;
			RATE_96: half_cnt = HALF_96;
			RATE_88: half_cnt = HALF_88;
			default: half_cnt = HALF_48;
		endcase
	endfunction

	// ==========================================================
	// registers and state
	logic [31:0] ctrl_q, coax_q, prdata_q;
	logic pready_q, pslverr_q;
	logic [N_SRC-1:1] vld_m_q, vld_s_q;
	logic [DIV_W-1:0] div_q;
	assl_state_t state_q;
	assl_ref_t cur_ref_q;
	logic [SRC_W-1:0] cur_src_q;
	logic [3:0] hold_q;
	logic sys_clk_q, pll_q, c2_out_q, c2_oe_q;

	// ==========================================================
	// apb decode
	wire acc_w = psel & penable & ~pready_q;
	wire done_w = psel & penable & pready_q;
	wire wr_w = done_w & pwrite;
	wire hit_ctrl_w = (paddr == OFS_CTRL);
	wire hit_coax_w = (paddr == OFS_COAX);
	wire hit_stat_w = (paddr == OFS_STAT);
	wire map_w = hit_ctrl_w | hit_coax_w | hit_stat_w;

	// ==========================================================
	// configuration fields
	// nine source codes
	wire [SRC_W-1:0] s1_sel_w = ctrl_q[CTL_S1_LSB +: SRC_W];
	wire [SRC_W-1:0] s2_sel_w = ctrl_q[CTL_S2_LSB +: SRC_W];
	wire s1_en_w = ctrl_q[CTL_S1_EN];
	wire s2_en_w = ctrl_q[CTL_S2_EN];
	wire [1:0] rate_w = ctrl_q[CTL_RATE_LSB +: 2];
	wire jit_w = ctrl_q[CTL_JIT];
	wire c2_req_w = ctrl_q[CTL_C2OUT];
	wire c2_fall_w = ctrl_q[CTL_C2FALL];
	wire [N_SRC-1:0] vld_w = {vld_s_q, 1'b1};

	// ==========================================================
	// source priority
	// source one first
	wire s1_ok_w = s1_en_w & src_ok(s1_sel_w, vld_w);
	wire s2_ok_w = s2_en_w & src_ok(s2_sel_w, vld_w);
	wire [1:0] want_ref_w = s1_ok_w ? REF_S1 : (s2_ok_w ? REF_S2 : REF_INT);
	wire [SRC_W-1:0] want_src_w = s1_ok_w ? s1_sel_w :
		(s2_ok_w ? s2_sel_w : SRC_INT);
	wire change_w = (want_ref_w != cur_ref_q) || (want_src_w != cur_src_q);
	wire cur_ok_w = src_ok(cur_src_q, vld_w);
	wire hold_done_w = (hold_q == 4'h0);

	// coax two chosen by a selector
	wire c2_chosen_w = (s1_en_w & is_coax2(s1_sel_w)) |
		(s2_en_w & is_coax2(s2_sel_w));

	// ==========================================================
	// edge taps
	// internal generator, all four rates
	wire int_tick_w = (div_q == '0);
	logic [N_SRC-1:0] tick_w;
	assign tick_w[0] = int_tick_w;

	genvar g;
	generate
		for (g = 1; g < N_SRC; g++) begin : g_tap
			wire fall_w = (is_coax1(SRC_W'(g)) & coax_q[CX_C1_FALL]) |
				(is_coax2(SRC_W'(g)) & coax_q[CX_C2_FALL]);
			assl_edge_tap u_tap (
				.clk(clk),
				.rst_n(rst_n),
				.pin(ref_pin[g]),
				.fall_sel(fall_w),
				.edge_pulse(tick_w[g])
			);
		end
	endgenerate

	wire cur_tick_w = tick_w[cur_src_q];

	// ==========================================================
	// read mux
	wire [31:0] stat_w = (32'(cur_ref_q) << STS_REF_LSB) |
		(32'(cur_src_q) << STS_SRC_LSB) |
		(32'(pll_q) << STS_PLL) |
		(32'(c2_oe_q) << STS_C2OE) |
		(32'(vld_w) << STS_VLD_LSB);
	wire [31:0] rdata_w = hit_ctrl_w ? ctrl_q :
		(hit_coax_w ? coax_q : (hit_stat_w ? stat_w : 32'h0000_0000));

	// ==========================================================
	// apb slave
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= acc_w;
			pslverr_q <= acc_w & ~map_w;
			if (acc_w) begin
				prdata_q <= rdata_w;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RST;
			coax_q <= COAX_RST;
		end else if (wr_w) begin
			if (hit_ctrl_w) begin
				ctrl_q <= pwdata & CTRL_MASK;
			end
			if (hit_coax_w) begin
				coax_q <= pwdata & COAX_MASK;
			end
		end
	end

	// ==========================================================
	// valid synchroniser
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vld_m_q <= '0;
			vld_s_q <= '0;
		end else begin
			vld_m_q <= src_valid;
			vld_s_q <= vld_m_q;
		end
	end

	// ==========================================================
	// internal generator
	// half period from rate
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_q <= '0;
		end else if (int_tick_w) begin
			div_q <= half_cnt(rate_w) - DIV_W'(1);
		end else begin
			div_q <= div_q - DIV_W'(1);
		end
	end

	// ==========================================================
	// switch state machine
	// park low, hold, then switch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_RUN;
			cur_ref_q <= REF_INT;
			cur_src_q <= SRC_INT;
			hold_q <= 4'h0;
			sys_clk_q <= 1'b0;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (change_w) begin
						state_q <= ST_PARK;
					end else if (cur_tick_w) begin
						sys_clk_q <= ~sys_clk_q;
					end
				end
				ST_PARK: begin
					if (!sys_clk_q) begin
						state_q <= ST_HOLD;
						hold_q <= HOLD_CYC;
					end else if (cur_tick_w || !cur_ok_w) begin
						sys_clk_q <= 1'b0;
					end
				end
				ST_HOLD: begin
					if (hold_done_w) begin
						state_q <= ST_RUN;
						cur_ref_q <= assl_ref_t'(want_ref_w);
						cur_src_q <= want_src_w;
					end else begin
						hold_q <= hold_q - 4'h1;
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// ==========================================================
	// pll and coax two output
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pll_q <= 1'b0;
			c2_oe_q <= 1'b0;
			c2_out_q <= 1'b0;
		end else begin
			pll_q <= jit_w & (cur_src_q != SRC_VIDEO);
			c2_oe_q <= c2_req_w & ~c2_chosen_w;
			c2_out_q <= (c2_req_w & ~c2_chosen_w) & (sys_clk_q ^ c2_fall_w);
		end
	end

	// ==========================================================
	// outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sys_clk = sys_clk_q;
	assign ref_src = cur_src_q;
	assign ref_active = cur_ref_q;
	assign rate_sel = ctrl_q[CTL_RATE_LSB +: 2];
	assign wide_range_pll = pll_q;
	assign coax1_term = coax_q[CX_C1_TERM];
	assign coax2_term = coax_q[CX_C2_TERM];
	assign coax2_out = c2_out_q;
	assign coax2_oe = c2_oe_q;

	// ==========================================================
	// checks
	master_hold_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_RUN && cur_ref_q == REF_S1 && s1_ok_w
		&& cur_src_q == s1_sel_w) |=> cur_ref_q == REF_S1)
		else $error("master source dropped while valid");
	failover_two_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_HOLD && hold_done_w && !s1_ok_w && s2_ok_w)
		|=> cur_ref_q == REF_S2 && cur_src_q == $past(s2_sel_w))
		else $error("no switch to source two");
	fallback_int_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_HOLD && hold_done_w && !s1_ok_w && !s2_ok_w)
		|=> cur_ref_q == REF_INT && cur_src_q == SRC_INT)
		else $error("no fall back to internal");
	int_period_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(int_tick_w && rate_w == RATE_96) ##1 (rate_w == RATE_96)
		|-> div_q == HALF_96 - DIV_W'(1))
		else $error("internal divider reload wrong");
	pll_video_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> pll_q == ($past(jit_w) && $past(cur_src_q) != SRC_VIDEO))
		else $error("wide range pll state wrong");
	coax2_out_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		c2_chosen_w |=> !c2_oe_q && !c2_out_q)
		else $error("coax two driven while chosen");
	coax2_phase_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		c2_oe_q |-> c2_out_q == ($past(sys_clk_q) ^ $past(c2_fall_w)))
		else $error("coax two phase wrong");
	term_follow_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(wr_w && hit_coax_w) |=> coax1_term == $past(pwdata[CX_C1_TERM])
		&& coax2_term == $past(pwdata[CX_C2_TERM]))
		else $error("termination not updated");
	switch_start_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_RUN && change_w) |=> state_q == ST_PARK
		&& sys_clk_q == $past(sys_clk_q))
		else $error("switch not started cleanly");
	park_low_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_PARK && !sys_clk_q) |=> state_q == ST_HOLD
		##1 (!sys_clk_q && state_q == ST_HOLD) [*4])
		else $error("clock not held low over switch");
	apb_ready_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		acc_w |=> pready_q ##1 !pready_q)
		else $error("apb ready not one cycle");

	failover_c: cover property (@(posedge clk) disable iff (!rst_n)
		cur_ref_q == REF_S1 ##[1:200] cur_ref_q == REF_S2);
	return_c: cover property (@(posedge clk) disable iff (!rst_n)
		cur_ref_q == REF_S2 ##[1:200] cur_ref_q == REF_S1);
	internal_c: cover property (@(posedge clk) disable iff (!rst_n)
		cur_ref_q == REF_S2 ##[1:200] cur_ref_q == REF_INT);
	coax2_drive_c: cover property (@(posedge clk) disable iff (!rst_n)
		c2_oe_q && $rose(c2_out_q));
endmodule

//--- verif/assl_ref_model.sv
// behavioural model of the external studio references
`timescale 1ns/1ps
module assl_ref_model import assl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// presence wanted by the bench
	input wire logic [N_SRC-1:1] vld,
	// reference lines
	output logic [N_SRC-1:1] ref_pin,
	output logic [N_SRC-1:1] src_valid
);
	// ==========================================================
	// square wave per source, noise while absent
	int cnt [N_SRC];
	always @(posedge clk) begin
		src_valid <= vld;
		for (int i = 1; i < N_SRC; i++) begin
			if (!rst_n || cnt[i] >= 18 + 2 * i)
				cnt[i] <= 0;
			else
				cnt[i] <= cnt[i] + 1;
			if (!rst_n)
				ref_pin[i] <= 1'b0;
			else if (!vld[i] || cnt[i] == 0)
				ref_pin[i] <= ~ref_pin[i];
		end
	end
endmodule

//--- verif/audio_sync_source_selector_tb.sv
// self-checking bench of the audio sync source selector
`timescale 1ns/1ps
module audio_sync_source_selector_tb import assl_pkg::*;;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, c, e;
	logic pready, pslverr, err, sys_clk, wide_range_pll, p;
	logic coax1_term, coax2_term, coax2_out, coax2_oe;
	logic [N_SRC-1:1] ref_pin, src_valid, vld = 8'h00;
	logic [SRC_W-1:0] ref_src;
	logic [1:0] ref_active, rate_sel;
	int n_mismatch = 0, n_compared = 0, seed = 74007, k;
	int fs [4] = '{FS_48K_HZ, FS_44K1_HZ, FS_96K_HZ, FS_88K2_HZ};
	logic [7:0] vt [4] = '{8'hFF, 8'hFD, 8'hFC, 8'hFF};

	// ==========================================================
	// design and reference model
	assl_sync_selector u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_pin(ref_pin), .src_valid(src_valid),
		.sys_clk(sys_clk), .ref_src(ref_src), .ref_active(ref_active),
		.rate_sel(rate_sel), .wide_range_pll(wide_range_pll),
		.coax1_term(coax1_term), .coax2_term(coax2_term),
		.coax2_out(coax2_out), .coax2_oe(coax2_oe));
	assl_ref_model u_ref (.clk(clk), .rst_n(rst_n), .vld(vld),
		.ref_pin(ref_pin), .src_valid(src_valid));

	initial forever #25 clk = ~clk;

	// ==========================================================
	// helpers
	task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, ex, got);
		end
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int t;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do begin
			tick(1);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (t >= 20)
			chk("pready", 32'h1, 32'h0);
		@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(string nm, logic [11:0] a, logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		chk(nm, ex, rd);
	endtask

	// priority model of the selection
	function automatic logic [5:0] model(logic [31:0] cw);
		logic [8:0] vv;
		vv = {vld, 1'b1};
		if (cw[8] && cw[3:0] < 9 && vv[cw[3:0]])
			return {cw[3:0], 2'h1};
		if (cw[9] && cw[7:4] < 9 && vv[cw[7:4]])
			return {cw[7:4], 2'h2};
		return 6'h00;
	endfunction

	task automatic setc(logic [31:0] cw);
		int t;
		c = cw;
		apb(1'b1, OFS_CTRL, cw);
		e = 32'(model(cw));
		t = 0;
		tick(4);
		while ({ref_src, ref_active} !== e[5:0] && t < 900) begin
			tick(1);
			t++;
		end
		chk("ref_sel", e, {ref_src, ref_active});
		apb(1'b0, OFS_STAT, 32'h0);
		chk("stat_sel", e, rd & 32'h3F);
		chk("stat_vld", {vld, 1'b1}, rd[16:8]);
	endtask

	task automatic wt();
		p = sys_clk;
		k = 0;
		while (sys_clk === p && k < 600) begin
			tick(1);
			k++;
		end
	endtask

	task automatic edg(logic fall);
		@(posedge ref_pin[1]);
		#1;
		p = sys_clk;
		tick(5);
		chk("edge", fall, sys_clk === p);
	endtask

	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// watchdog
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		chk("rst_sel", 32'h0, {ref_src, ref_active, coax2_oe});
		rdc("ctrl_rst", OFS_CTRL, CTRL_RST);
		rdc("coax_rst", OFS_COAX, COAX_RST);
		rdc("stat_rst", OFS_STAT, 32'h0000_0100);
		apb(1'b1, OFS_STAT, 32'hFFFF_FFFF);
		chk("stat_ro", 32'h0, err);
		rdc("stat_keep", OFS_STAT, 32'h0000_0100);
		apb(1'b0, 12'h00C, 32'h0);
		chk("bad_rd", 32'h0, rd);
		chk("bad_err", 32'h1, err);
		apb(1'b1, 12'h002, 32'hFFFF_FFFF);
		chk("bad_wr", 32'h1, err);
		apb(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
		rdc("ctrl_mask", OFS_CTRL, CTRL_MASK);
		// internal generator at every rate
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, OFS_CTRL, 32'(r) << CTL_RATE_LSB);
			wt();
			wt();
			chk("half", CLK_HZ / (2 * fs[r]), k);
			chk("rate", r, rate_sel);
		end
		// every source code on selector one
		@(posedge clk);
		vld <= 8'hFF;
		for (int s = 0; s < N_SRC; s++)
			setc(32'h100 | s);
		// failover and return
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			vld <= vt[i];
			setc(32'h312);
		end
		// random codes and presence
		for (int i = 0; i < 24; i++) begin
			@(posedge clk);
			vld <= 8'($random(seed));
			setc(32'($random(seed)) & 32'h3FF);
		end
		@(posedge clk);
		vld <= 8'hFF;
		setc(32'h1101);
		chk("pll_on", 32'h1, wide_range_pll);
		setc(32'h1108);
		chk("pll_video", 32'h0, wide_range_pll);
		// coax one edge and terminations
		setc(32'h101);
		apb(1'b1, OFS_COAX, 32'hFFFF_FFFA);
		tick(50);
		chk("terms", 32'h3, {coax1_term, coax2_term});
		edg(1'b0);
		apb(1'b1, OFS_COAX, 32'hFFFF_FFF5);
		tick(50);
		chk("terms_off", 32'h0, {coax1_term, coax2_term});
		rdc("coax_rd", OFS_COAX, 32'h5);
		edg(1'b1);
		// coax two as output
		for (int f = 0; f < 2; f++) begin
			setc(32'h2101 | (f << CTL_C2FALL));
			chk("c2_oe", 32'h1, coax2_oe);
			for (int i = 0; i < 120; i++) begin
				p = sys_clk ^ c[CTL_C2FALL];
				tick(1);
				chk("c2_out", p, coax2_out);
			end
		end
		setc(32'h2121);
		chk("c2_idle", 32'h1, coax2_oe);
		setc(32'h2321);
		chk("c2_taken", 32'h0, coax2_oe);
		// reset in mid run
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		chk("rst2_sel", 32'h0, {ref_src, ref_active, coax2_oe});
		chk("rst2_rate", 32'h0, rate_sel);
		rdc("rst2_ctrl", OFS_CTRL, CTRL_RST);
		finish_test();
	end
endmodule
